// [src/conv_seq.sv]
// Per-channel conversion sequencer with chopping, scaling and calibration.
//
// Local design decisions: the plain strobed port and the address map.
`timescale 1ns/1ps
`include "conv_seq_defs.svh"
module conv_seq #(
    parameter int unsigned NCH       = 2,
    parameter int unsigned SAMP_UNIT = 16
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [3:0]  addr,
    input  wire logic [23:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [23:0] rdata,
    input  wire logic        mod_valid,
    input  wire logic [23:0] mod_result,
    input  wire logic        ref_low,
    output logic             mux_reverse,
    output logic             inputs_shorted,
    output logic      [0:0]  mux_channel,
    output logic             ready_n,
    input  wire logic        general_io_a_in,
    output logic             general_io_a_out,
    output logic             general_io_a_oe,
    input  wire logic        general_io_b_in,
    output logic             general_io_b_out,
    output logic             general_io_b_oe,
    output conv_seq_pkg::state_t state
);
    import conv_seq_pkg::*;

    logic [23:0] adc_zs_reg, adc_fs_reg;
    logic [23:0] ch_zs_reg [NCH];
    logic [23:0] ch_fs_reg [NCH];
    logic [23:0] data_reg  [NCH];
    logic [7:0]  conv_t_reg [NCH];
    logic [7:0]  ch_stat_reg [NCH];
    logic [7:0]  status_reg, ioport_reg;
    logic [7:0]  mode_reg;
    logic [1:0]  ch_en_reg;
    logic [0:0]  chan_reg;
    logic        bipolar_reg;
    state_t      state_reg;
    logic [15:0] cnt_reg;
    logic [23:0] samp1_reg, samp2_reg, rdata_reg;
    logic        settle_extra_reg, ready_n_reg, data_rd_reg;
    logic        sync_q1, sync_q2, sync_q3, sync_lvl_reg;
    logic        refl_q1, refl_q2, refl_q3, refl_lvl_reg;
    logic [1:0]  dat_q1, dat_q2, dat_q3, dat_lvl_reg;

    // Channel zero-scale as sign plus 22-bit magnitude
    function automatic logic signed [47:0] zs_val(input logic [23:0] z);
        zs_val = z[23] ? -48'(z[21:0]) : 48'(z[21:0]);
    endfunction

    function automatic logic [23:0] clip24(input logic signed [63:0] v);
        if (v < 0)
            clip24 = 24'h000000;
        else if (v > 64'sh0FFFFFF)
            clip24 = 24'hFFFFFF;
        else
            clip24 = v[23:0];
    endfunction

    // Raw result unsigned 24-bit, scaled through both stages
    function automatic logic [23:0] scale(input logic [23:0] raw, input logic bip,
                                          input logic [23:0] czs, input logic [23:0] cfs);
        logic signed [63:0] t;
        t = 64'($signed({40'h0, raw})) - 64'($signed({40'h0, adc_zs_reg}));
        t = t * 64'($signed({40'h0, adc_fs_reg}));
        if (bip)
            t = t / 64'(`SCALE_B) + 64'(`BIP_OFFSET);
        else
            t = t / 64'(`SCALE_U);
        t = t - 64'(zs_val(czs));
        t = t * 64'($signed({40'h0, cfs})) / 64'(`SCALE_U);
        scale = clip24(t);
    endfunction

    wire sel_ch = chan_reg[0];
    wire [7:0] sel_ct = conv_t_reg[sel_ch];
    wire chop_on = sel_ct[`CONVT_CHOP];
    wire [15:0] samp_len = 16'(sel_ct[6:0]) * 16'(SAMP_UNIT) + 16'h0001;
    wire [15:0] settle_len = `SETTLE_FIRST + 16'(settle_extra_reg);
    wire mode_t cur_mode = mode_t'(mode_reg[7:5]);
    wire is_cal = cur_mode[2];
    wire conv_mode = (cur_mode == MODE_CONT) || (cur_mode == MODE_SINGLE) || is_cal;
    wire sync_hold = ioport_reg[`IO_SYNC_EN] && !sync_lvl_reg;
    wire cnt_done = (cnt_reg == 16'h0001);
    wire [23:0] avg = 24'((25'(samp1_reg) + 25'(samp2_reg)) >> 1);
    wire [0:0] next_ch = (ch_en_reg[!sel_ch]) ? !sel_ch : sel_ch;
    wire wr_mode = wr && (addr == `OFS_MODE);
    wire data_read = rd && (addr == `OFS_DATA0 || addr == `OFS_DATA0 + 4'h1);
    wire [23:0] result = chop_on ? avg : samp1_reg;

    assign state = state_reg;
    assign ready_n = ready_n_reg;
    assign rdata = rdata_reg;
    assign mux_reverse = (state_reg == ST_SETTLE2) || (state_reg == ST_SAMP2);
    assign inputs_shorted = is_cal && (cur_mode == MODE_ZS_SELF);
    assign mux_channel = chan_reg;
    assign general_io_a_out = ioport_reg[0];
    assign general_io_a_oe = ioport_reg[`IO_DIR_A];
    assign general_io_b_out = ioport_reg[1];
    assign general_io_b_oe = ioport_reg[`IO_DIR_B] && !ioport_reg[`IO_SYNC_EN];

    // Pin synchronisers, change taken when second and third agree
    always_ff @(posedge clk) begin
        sync_q1 <= general_io_b_in;
        sync_q2 <= sync_q1;
        sync_q3 <= sync_q2;
        refl_q1 <= ref_low;
        refl_q2 <= refl_q1;
        refl_q3 <= refl_q2;
        dat_q1 <= {general_io_b_in, general_io_a_in};
        dat_q2 <= dat_q1;
        dat_q3 <= dat_q2;
        if (rst) begin
            sync_lvl_reg <= 1'b1;
            refl_lvl_reg <= 1'b0;
            dat_lvl_reg <= 2'h0;
        end else begin
            if (sync_q2 == sync_q3) sync_lvl_reg <= sync_q3;
            if (refl_q2 == refl_q3) refl_lvl_reg <= refl_q3;
            if (dat_q2 == dat_q3) dat_lvl_reg <= dat_q3;
        end
    end

    // Read mux
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_reg <= 24'h000000;
        end else if (rd) begin
            case (addr)
                `OFS_STATUS:        rdata_reg <= {16'h0, status_reg};
                `OFS_MODE:          rdata_reg <= {16'h0, mode_reg};
                `OFS_IOPORT:        rdata_reg <= {16'h0, ioport_reg[7:2], dat_lvl_reg};
                `OFS_ADC_ZS:        rdata_reg <= adc_zs_reg;
                `OFS_ADC_FS:        rdata_reg <= adc_fs_reg;
                `OFS_CH_STAT0:      rdata_reg <= {16'h0, ch_stat_reg[0]};
                `OFS_CH_STAT0+4'h1: rdata_reg <= {16'h0, ch_stat_reg[1]};
                `OFS_DATA0:         rdata_reg <= data_reg[0];
                `OFS_DATA0+4'h1:    rdata_reg <= data_reg[1];
                `OFS_CH_ZS0:        rdata_reg <= ch_zs_reg[0];
                `OFS_CH_ZS0+4'h1:   rdata_reg <= ch_zs_reg[1];
                `OFS_CH_FS0:        rdata_reg <= ch_fs_reg[0];
                `OFS_CH_FS0+4'h1:   rdata_reg <= ch_fs_reg[1];
                `OFS_CONV_T0:       rdata_reg <= {16'h0, conv_t_reg[0]};
                `OFS_CONV_T0+4'h1:  rdata_reg <= {16'h0, conv_t_reg[1]};
                default:            rdata_reg <= {8'h0, 6'h0, ch_en_reg, 7'h0, bipolar_reg};
            endcase
        end
    end

    // Sequencer
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            cnt_reg <= 16'h0000;
            mode_reg <= 8'h00;
            ioport_reg <= 8'h00;
            status_reg <= 8'h00;
            ready_n_reg <= 1'b1;
            chan_reg <= 1'b0;
            ch_en_reg <= 2'h3;
            bipolar_reg <= 1'b1;
            settle_extra_reg <= 1'b0;
            samp1_reg <= 24'h000000;
            samp2_reg <= 24'h000000;
            data_rd_reg <= 1'b0;
            adc_zs_reg <= `ADC_ZS_RST;
            adc_fs_reg <= `ADC_FS_RST;
            for (int i = 0; i < NCH; i++) begin
                ch_zs_reg[i] <= `CH_ZS_RST;
                ch_fs_reg[i] <= `CH_FS_RST;
                data_reg[i] <= 24'h000000;
                conv_t_reg[i] <= `CONV_T_RST;
                ch_stat_reg[i] <= 8'h00;
            end
        end else begin
            data_rd_reg <= data_read;
            if (wr) begin
                case (addr)
                    `OFS_IOPORT: ioport_reg <= wdata[7:0];
                    `OFS_MODE:   mode_reg <= wdata[7:0];
                    // Calibration writes honoured only in idle
                    `OFS_ADC_ZS: if (state_reg == ST_IDLE) adc_zs_reg <= wdata;
                    `OFS_ADC_FS: if (state_reg == ST_IDLE) adc_fs_reg <= wdata;
                    `OFS_CH_ZS0, `OFS_CH_ZS0+4'h1:
                        if (state_reg == ST_IDLE) ch_zs_reg[addr[0] ^ 1'b1] <= wdata;
                    `OFS_CH_FS0, `OFS_CH_FS0+4'h1:
                        if (state_reg == ST_IDLE) ch_fs_reg[addr[0] ^ 1'b1] <= wdata;
                    `OFS_CONV_T0, `OFS_CONV_T0+4'h1:
                        conv_t_reg[addr[0] ^ 1'b1] <= wdata[7:0];
                    4'hF: begin
                        ch_en_reg <= wdata[9:8];
                        bipolar_reg <= wdata[0];
                    end
                    default: ;
                endcase
            end
            if (state_reg != ST_IDLE && state_reg != ST_SYNC && refl_lvl_reg)
                ch_stat_reg[sel_ch][4] <= 1'b1;
            cnt_reg <= cnt_reg - 16'h0001;
            case (state_reg)
                ST_IDLE: begin
                    if (wr_mode && mode_t'(wdata[7:5]) != MODE_IDLE
                        && mode_t'(wdata[7:5]) != MODE_STDBY) begin
                        chan_reg <= wdata[`MODE_CHAN];
                        state_reg <= ST_SYNC;
                    end
                end
                ST_SYNC: begin
                    if (!sync_hold) begin
                        state_reg <= ST_SETTLE;
                        cnt_reg <= settle_len;
                        settle_extra_reg <= !settle_extra_reg;
                    end
                end
                ST_SETTLE: if (cnt_done) begin
                    state_reg <= ST_SAMP1;
                    cnt_reg <= samp_len;
                end
                ST_SAMP1: begin
                    if (mod_valid) samp1_reg <= mod_result;
                    if (cnt_done) begin
                        state_reg <= chop_on ? ST_SETTLE2 : ST_SCALE;
                        cnt_reg <= chop_on ? `SETTLE_CHOP : `SCALE_CYCLES;
                        if (!chop_on) ready_n_reg <= 1'b1;
                    end
                end
                ST_SETTLE2: if (cnt_done) begin
                    state_reg <= ST_SAMP2;
                    cnt_reg <= samp_len;
                end
                ST_SAMP2: begin
                    if (mod_valid) samp2_reg <= mod_result;
                    if (cnt_done) begin
                        state_reg <= ST_SCALE;
                        cnt_reg <= `SCALE_CYCLES;
                        ready_n_reg <= 1'b1;
                    end
                end
                ST_SCALE: if (cnt_done) begin
                    if (is_cal) begin
                        case (cur_mode)
                            MODE_ZS_SELF: adc_zs_reg <= result;
                            MODE_ZS_SYS:  ch_zs_reg[sel_ch] <= result;
                            default:      ch_fs_reg[sel_ch] <= result;
                        endcase
                        status_reg <= 8'hFF;
                        ready_n_reg <= 1'b0;
                        mode_reg[7:5] <= MODE_IDLE;
                        state_reg <= ST_IDLE;
                    end else begin
                        if (!data_read && !data_rd_reg) begin
                            data_reg[sel_ch] <= scale(result, bipolar_reg,
                                                      ch_zs_reg[sel_ch], ch_fs_reg[sel_ch]);
                            status_reg[sel_ch] <= 1'b1;
                            ch_stat_reg[sel_ch][3] <= 1'b1;
                            ready_n_reg <= 1'b0;
                        end
                        if (cur_mode == MODE_CONT && !conv_mode_stop()) begin
                            chan_reg <= next_ch;
                            state_reg <= ST_SYNC;
                        end else begin
                            mode_reg[7:5] <= MODE_IDLE;
                            state_reg <= ST_IDLE;
                        end
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
            // Software abort to idle overrides
            if (wr_mode && mode_t'(wdata[7:5]) == MODE_IDLE) state_reg <= ST_IDLE;
            // Reading data clears that channel's ready flag unless scaling completes on that edge
            if (data_read && !(state_reg == ST_SCALE && cnt_done))
                status_reg[addr[0] ^ 1'b1] <= 1'b0;
        end
    end

    function automatic logic conv_mode_stop();
        conv_mode_stop = !conv_mode;
    endfunction

    a_settle_to_samp: assert property (@(posedge clk) disable iff (rst || wr_mode)
        state_reg == ST_SYNC && !sync_hold |=> state_reg == ST_SETTLE [*8])
        else $error("settling too short");
    a_scale_ready_hi: assert property (@(posedge clk) disable iff (rst)
        state_reg != ST_SCALE ##1 state_reg == ST_SCALE |-> ready_n_reg)
        else $error("ready not high in scaling");
    a_nochop_single: assert property (@(posedge clk) disable iff (rst)
        state_reg == ST_SAMP1 && cnt_done && !chop_on |=> state_reg == ST_SCALE)
        else $error("unchopped cycle sampled twice");
    a_chop_settle2: assert property (@(posedge clk) disable iff (rst || wr_mode)
        state_reg == ST_SAMP1 && cnt_done && chop_on |=> state_reg == ST_SETTLE2 [*8])
        else $error("chop settle missing");
    a_scale_len: assert property (@(posedge clk) disable iff (rst || wr_mode)
        state_reg == ST_SAMP2 && cnt_done |=> state_reg == ST_SCALE [*8])
        else $error("scaling cut short");
    a_sync_hold: assert property (@(posedge clk) disable iff (rst)
        state_reg == ST_SYNC && sync_hold |=> state_reg != ST_SETTLE)
        else $error("conversion started under sync hold");
    a_reverse_mux: assert property (@(posedge clk) disable iff (rst)
        state_reg == ST_SAMP2 |-> mux_reverse)
        else $error("second sample not reversed");
    a_missing_reference_flag_flag: assert property (@(posedge clk) disable iff (rst)
        state_reg == ST_SAMP1 && refl_lvl_reg |=> ch_stat_reg[$past(sel_ch)][4])
        else $error("missing reference not flagged");
    c_chop_cycle: cover property (@(posedge clk) state_reg == ST_SAMP2 && cnt_done);
    c_cal_done: cover property (@(posedge clk) state_reg == ST_SCALE && cnt_done && is_cal);
    c_cont_step: cover property (@(posedge clk)
        state_reg == ST_SCALE && cnt_done && cur_mode == MODE_CONT);
endmodule

// [src/conv_seq_defs.svh]
// Constants for the conversion sequencer: register offsets, fields, timing.
`ifndef CONV_SEQ_DEFS_SVH
`define CONV_SEQ_DEFS_SVH
`define OFS_STATUS    4'h0
`define OFS_MODE      4'h1
`define OFS_IOPORT    4'h2
`define OFS_ADC_ZS    4'h3
`define OFS_ADC_FS    4'h4
`define OFS_CH_STAT0  4'h5
`define OFS_DATA0     4'h7
`define OFS_CH_ZS0    4'h9
`define OFS_CH_FS0    4'hB
`define OFS_CONV_T0   4'hD
`define SETTLE_FIRST  16'h002B
`define SETTLE_CHOP   16'h002A
`define SCALE_CYCLES  16'h00A3
`define SCALE_U       24'h200000
`define SCALE_B       24'h400000
`define BIP_OFFSET    24'h800000
`define ADC_ZS_RST    24'h000000
`define ADC_FS_RST    24'h200000
`define CH_ZS_RST     24'h000000
`define CH_FS_RST     24'h200000
`define CONV_T_RST    8'h91
`define CONVT_CHOP    7
`define MODE_LSB      5
`define MODE_CHAN     0
`define IO_SYNC_EN    4
`define IO_DIR_A      2
`define IO_DIR_B      3
`endif

// [src/conv_seq_pkg.sv]
// Types shared by the conversion sequencer.
package conv_seq_pkg;
    typedef enum logic [2:0] {
        MODE_IDLE   = 3'h0,
        MODE_CONT   = 3'h1,
        MODE_SINGLE = 3'h2,
        MODE_STDBY  = 3'h3,
        MODE_ZS_SELF = 3'h4,
        MODE_ZS_SYS = 3'h6,
        MODE_FS_SYS = 3'h7
    } mode_t;
    typedef enum logic [2:0] {
        ST_IDLE   = 3'h0,
        ST_SYNC   = 3'h1,
        ST_SETTLE = 3'h2,
        ST_SAMP1  = 3'h3,
        ST_SETTLE2 = 3'h4,
        ST_SAMP2  = 3'h5,
        ST_SCALE  = 3'h6
    } state_t;
endpackage

// [tb/conv_front_model.sv]
// Behavioural modulator and filter front end for the sequencer bench.
`timescale 1ns/1ps
module conv_front_model #(
    parameter logic [23:0] BASE0 = 24'h100000,
    parameter logic [23:0] BASE1 = 24'h200000,
    parameter logic [23:0] OFFS  = 24'h000100
) (
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire conv_seq_pkg::state_t state,
    input  wire logic                 mux_reverse,
    input  wire logic                 inputs_shorted,
    input  wire logic [0:0]           mux_channel,
    output logic                      mod_valid,
    output logic [23:0]               mod_result
);
    import conv_seq_pkg::*;
    logic [23:0] idle_pat;
    logic [23:0] base_sel;
    logic [23:0] sample_val;
    assign base_sel   = mux_channel[0] ? BASE1 : BASE0;
    // Offset term flips sign with input polarity
    assign sample_val = inputs_shorted ? OFFS :
                        mux_reverse ? base_sel - OFFS : base_sel + OFFS;
    assign mod_valid  = (state == ST_SAMP1) || (state == ST_SAMP2);
    assign mod_result = mod_valid ? sample_val : idle_pat;
    // Released bus changes every cycle out of reset, holds in reset
    always_ff @(posedge clk) begin
        if (rst) begin
            idle_pat <= 24'hA5A5A5;
        end else begin
            idle_pat <= ~idle_pat;
        end
    end
endmodule

// [tb/conv_seq_tb_top.sv]
// Self-checking bench for the conversion sequencer.
`timescale 1ns/1ps
`include "conv_seq_defs.svh"
module conv_seq_tb_top;
    import conv_seq_pkg::*;
    localparam logic [23:0] B0 = 24'h123400;
    localparam logic [23:0] B1 = 24'h456700;
    localparam logic [23:0] OF = 24'h000200;
    logic        clk         = 1'b0;
    logic        rst         = 1'b1;
    logic [3:0]  addr        = 4'h0;
    logic [23:0] wdata       = 24'h000000;
    logic        wr          = 1'b0;
    logic        rd          = 1'b0;
    logic        ref_low     = 1'b0;
    logic        sync_pin    = 1'b0;
    logic [23:0] rdata, mod_result, rv;
    logic        mod_valid, mux_reverse, inputs_shorted, ready_n;
    logic [0:0]  mux_channel;
    logic        a_out, a_oe, b_out, b_oe, a_in, b_in;
    state_t      state;
    state_t      prev_st     = ST_IDLE;
    int          fail_count  = 0;
    int          check_count = 0;
    int          cycles      = 0;
    int          run         = 0;
    int          dur[8];

    always #20 clk = ~clk;
    // Pin a pulled up when released; pin b carries sync when released
    assign a_in = a_oe ? a_out : 1'b1;
    assign b_in = b_oe ? b_out : sync_pin;

    conv_seq #(.NCH(2), .SAMP_UNIT(1)) DUT (
        .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .mod_valid(mod_valid), .mod_result(mod_result),
        .ref_low(ref_low), .mux_reverse(mux_reverse), .inputs_shorted(inputs_shorted),
        .mux_channel(mux_channel), .ready_n(ready_n), .general_io_a_in(a_in),
        .general_io_a_out(a_out), .general_io_a_oe(a_oe), .general_io_b_in(b_in),
        .general_io_b_out(b_out), .general_io_b_oe(b_oe), .state(state));

    conv_front_model #(.BASE0(B0), .BASE1(B1), .OFFS(OF)) FRONT (
        .clk(clk), .rst(rst), .state(state), .mux_reverse(mux_reverse),
        .inputs_shorted(inputs_shorted), .mux_channel(mux_channel),
        .mod_valid(mod_valid), .mod_result(mod_result));

    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Phase lengths and polarity watched on every cycle
    always @(posedge clk) begin
        cycles <= cycles + 1;
        prev_st <= state;
        if (state == prev_st) begin
            run <= run + 1;
        end else begin
            dur[prev_st] <= run;
            run <= 1;
        end
        if (!rst && state == ST_SCALE && prev_st == ST_SCALE) begin
            chk("ready_n in scale", 24'h000001, {23'h0, ready_n});
        end
        if (!rst && (state == ST_SAMP1 || state == ST_SAMP2)) begin
            chk("mux_reverse", {23'h0, state == ST_SAMP2}, {23'h0, mux_reverse});
        end
        if (cycles == 20000) begin
            chk("timeout", 24'h000000, 24'h000001);
            end_sim();
        end
    end

    task automatic wr_reg(input logic [3:0] a, input logic [23:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask

    task automatic rd_reg(input logic [3:0] a, output logic [23:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic rd_chk(input string nm, input logic [3:0] a, input logic [23:0] exp);
        logic [23:0] d;
        rd_reg(a, d);
        chk(nm, exp, d);
    endtask

    task automatic start(input mode_t m, input logic ch);
        foreach (dur[i]) dur[i] = 0;
        wr_reg(`OFS_MODE, {16'h0000, m, 4'h0, ch});
    endtask

    task automatic wait_done();
        bit in_scale;
        in_scale = 0;
        for (int i = 0; i < 3000; i++) begin
            @(posedge clk);
            #1;
            if (state == ST_SCALE) in_scale = 1;
            else if (in_scale && ready_n === 1'b0) return;
        end
        chk("completion", 24'h000001, 24'h000000);
    endtask

    task automatic chk_times(input int len, input bit chop);
        repeat (2) @(posedge clk);
        #1;
        chk("settle", 24'h000001, {23'h0, dur[ST_SETTLE] inside {43, 44}});
        chk("sample", 24'(len + 1), 24'(dur[ST_SAMP1]));
        chk("settle2", chop ? 24'h00002A : 24'h000000, 24'(dur[ST_SETTLE2]));
        chk("sample2", chop ? 24'(len + 1) : 24'h000000, 24'(dur[ST_SAMP2]));
        chk("scale", 24'h0000A3, 24'(dur[ST_SCALE]));
    endtask

    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk("ready_n reset", 24'h000001, {23'h0, ready_n});
        chk("rdata reset", 24'h000000, rdata);
        rd_chk("conv_t0", `OFS_CONV_T0, 24'(`CONV_T_RST));
        rd_chk("ch_fs0", `OFS_CH_FS0, `CH_FS_RST);
        rd_chk("adc_fs", `OFS_ADC_FS, `ADC_FS_RST);
        rd_chk("ch_zs0", `OFS_CH_ZS0, `CH_ZS_RST);
        $display("test reset values done");
        wr_reg(`OFS_CONV_T0, 24'h000002);
        wr_reg(4'hF, 24'h000300);
        start(MODE_SINGLE, 1'b0);
        wait_done();
        chk_times(2, 1'b0);
        chk("ready_n done", 24'h000000, {23'h0, ready_n});
        rd_chk("status", `OFS_STATUS, 24'h000001);
        rd_reg(`OFS_CH_STAT0, rv);
        chk("ch ready", 24'h000001, {23'h0, rv[3]});
        rd_chk("data0", `OFS_DATA0, B0 + OF);
        rd_chk("status read", `OFS_STATUS, 24'h000000);
        $display("test single conversion done");
        wr_reg(`OFS_CONV_T0 + 4'h1, 24'h000083);
        start(MODE_CONT, 1'b0);
        wait_done();
        chk_times(2, 1'b0);
        chk("next channel", 24'h000001, {23'h0, mux_channel});
        wr_reg(`OFS_CH_ZS0 + 4'h1, 24'h000100);
        wait_done();
        chk_times(3, 1'b1);
        wr_reg(`OFS_MODE, 24'h000000);
        rd_chk("data1", `OFS_DATA0 + 4'h1, B1);
        rd_chk("ch_zs1 busy", `OFS_CH_ZS0 + 4'h1, `CH_ZS_RST);
        $display("test continuous done");
        wr_reg(`OFS_IOPORT, 24'h000010);
        start(MODE_SINGLE, 1'b0);
        repeat (60) @(posedge clk);
        #1;
        chk("sync hold", 24'(ST_SYNC), 24'(state));
        @(posedge clk);
        sync_pin <= 1'b1;
        repeat (30) @(posedge clk);
        ref_low <= 1'b1;
        wait_done();
        chk_times(2, 1'b0);
        @(posedge clk);
        ref_low <= 1'b0;
        rd_reg(`OFS_CH_STAT0, rv);
        chk("missing ref", 24'h000001, {23'h0, rv[4]});
        $display("test sync and reference done");
        wr_reg(`OFS_IOPORT, 24'h000005);
        chk("a pin", 24'h000003, {22'h0, a_out, a_oe});
        rd_reg(`OFS_IOPORT, rv);
        chk("pins", 24'h000003, {22'h0, rv[1:0]});
        wr_reg(`OFS_IOPORT, 24'h000008);
        chk("b pin", 24'h000001, {22'h0, b_out, b_oe});
        // Pin level needs the synchroniser to settle
        repeat (3) @(posedge clk);
        rd_reg(`OFS_IOPORT, rv);
        chk("pins", 24'h000001, {22'h0, rv[1:0]});
        wr_reg(`OFS_IOPORT, 24'h000000);
        $display("test general io done");
        rd_reg(`OFS_DATA0, rv);
        rd_reg(`OFS_DATA0 + 4'h1, rv);
        start(MODE_ZS_SYS, 1'b0);
        wait_done();
        chk_times(2, 1'b0);
        chk("cal idle", 24'(ST_IDLE), 24'(state));
        rd_reg(`OFS_STATUS, rv);
        chk("cal ready", 24'h000003, {22'h0, rv[1:0]});
        rd_chk("cal zs0", `OFS_CH_ZS0, B0 + OF);
        start(MODE_FS_SYS, 1'b0);
        wait_done();
        rd_chk("cal fs0", `OFS_CH_FS0, B0 + OF);
        start(MODE_SINGLE, 1'b0);
        wait_done();
        rd_chk("unipolar", `OFS_DATA0, 24'h000000);
        wr_reg(4'hF, 24'h000301);
        wr_reg(`OFS_CH_ZS0, 24'h000000);
        wr_reg(`OFS_CH_FS0, 24'h100000);
        start(MODE_SINGLE, 1'b0);
        wait_done();
        rd_chk("bipolar", `OFS_DATA0, 24'h448D80);
        // Data read lands on the completing edge: result dropped
        start(MODE_SINGLE, 1'b0);
        for (int i = 0; i < 400 && state != ST_SCALE; i++) begin
            @(posedge clk);
            #1;
        end
        repeat (161) @(posedge clk);
        rd_reg(`OFS_DATA0, rv);
        chk("discard ready_n", 24'h000001, {23'h0, ready_n});
        rd_reg(`OFS_STATUS, rv);
        chk("discard status", 24'h000000, {23'h0, rv[0]});
        chk("discard idle", 24'(ST_IDLE), 24'(state));
        start(MODE_ZS_SELF, 1'b0);
        repeat (20) @(posedge clk);
        #1;
        chk("shorted", 24'h000001, {23'h0, inputs_shorted});
        wait_done();
        rd_chk("self zs", `OFS_ADC_ZS, OF);
        $display("test calibration done");
        end_sim();
    end
endmodule
